// file: core/tw_dev.sv
// module end: two-wire slave giving byte access to paged management memory
// What this block does
// R1: current-address read returns byte at pointer
// R2: host nacks single read byte, then stops
// R3: host loads address by dummy write, restart
// R4: random read acks all, returns loaded byte
// R5: host ack makes device send next byte
// R6: nack and stop end reads, release line
// R7: byte write acks address, offset, data
// R8: write commits only on stop
// R9: restart instead of stop discards write
// R10: stop after data runs timed write cycle
// R11: write cycle ignores bus, acks nothing
// R12: host never ends writes with restart
// R13: at most four bytes per write
// R14: each of the first four data bytes is acked
// R15: unterminated sequential write is discarded
// R16: lower space 0..127, upper pages above
// R17: pages 00, 02, 03 exist; 01 absent
// R18: respond only while module select low
// R19: byte 127 selects upper page
// R20: pointer advances, persists between transfers
// R21: msb first, one ack slot per byte
module tw_dev import tw_pkg::*; #(
   parameter int TWR_CYCLES = TWR_CYC
) (
   input wire logic clk_sys,
   input wire logic rst,
   tw_link_if.dev link,
   output logic busy,
   output logic [7:0] page_sel
);

   // ****************************************
   // pin synchronisers and line events
   // ****************************************
   logic scl_s1_r;
   logic scl_s2_r;
   logic scl_q_r;
   logic sda_s1_r;
   logic sda_s2_r;
   logic sda_q_r;
   logic msel_s1_r;
   logic msel_s2_r;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         scl_s1_r <= 1'b1;
         scl_s2_r <= 1'b1;
         scl_q_r <= 1'b1;
         sda_s1_r <= 1'b1;
         sda_s2_r <= 1'b1;
         sda_q_r <= 1'b1;
         msel_s1_r <= 1'b1;
         msel_s2_r <= 1'b1;
      end else begin
         scl_s1_r <= link.scl;
         scl_s2_r <= scl_s1_r;
         scl_q_r <= scl_s2_r;
         sda_s1_r <= link.sda;
         sda_s2_r <= sda_s1_r;
         sda_q_r <= sda_s2_r;
         msel_s1_r <= link.module_select_n;
         msel_s2_r <= msel_s1_r;
      end
   end

   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   logic selected;
   assign scl_rise = scl_s2_r && !scl_q_r;
   assign scl_fall = !scl_s2_r && scl_q_r;
   assign start_det = scl_s2_r && scl_q_r && sda_q_r && !sda_s2_r;
   assign stop_det = scl_s2_r && scl_q_r && !sda_q_r && sda_s2_r;
   assign selected = !msel_s2_r;

   // ****************************************
   // memory and page mapping
   // ****************************************
   logic [7:0] mem_r [0:MEM_BYTES-1];

   // returns {hit, bank, offset}; upper bytes under page 01 and unknown pages miss, lower bytes always hit
   function automatic logic [9:0] map_addr(input logic [7:0] a, input logic [7:0] pg);
      if (a <= LOWER_TOP) begin
         map_addr = {1'b1, BANK_LOWER, a[6:0]}; // [R16]
      end else if (pg == PAGE_00) begin
         map_addr = {1'b1, BANK_P00, a[6:0]}; // [R17]
      end else if (pg == PAGE_02) begin
         map_addr = {1'b1, BANK_P02, a[6:0]}; // [R17]
      end else if (pg == PAGE_03) begin
         map_addr = {1'b1, BANK_P03, a[6:0]}; // [R17]
      end else begin
         map_addr = {1'b0, 9'h000};
      end
   endfunction : map_addr

   assign page_sel = mem_r[{BANK_LOWER, PAGE_SEL_ADDR[6:0]}]; // [R19]

   // ****************************************
   // protocol state machine
   // ****************************************
   tw_dev_st_t st_r;
   tw_kind_t kind_r;
   logic [3:0] bit_cnt_r;
   logic [7:0] shift_r;
   logic [7:0] ptr_r;
   logic [7:0] waddr_r;
   logic [2:0] wcnt_r;
   logic [7:0] wbuf_r [0:3];
   logic rd_mode_r;
   logic ack_r;
   logic oe_r;
   logic [23:0] twr_cnt_r;
   logic [2:0] wi_r;
   logic [9:0] rd_map;
   logic [7:0] rd_byte;
   logic twr_done;

   assign rd_map = map_addr(ptr_r, page_sel);
   assign rd_byte = rd_map[9] ? mem_r[rd_map[8:0]] : UNMAPPED_DATA;
   assign twr_done = (twr_cnt_r == 24'(TWR_CYCLES - 1));

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_r <= ST_IDLE;
         kind_r <= K_DEV;
         bit_cnt_r <= 4'h0;
         shift_r <= 8'h00;
         ptr_r <= 8'h00;
         waddr_r <= 8'h00;
         wcnt_r <= 3'h0;
         rd_mode_r <= 1'b0;
         ack_r <= 1'b0;
         oe_r <= 1'b0;
         for (int i = 0; i < 4; i++) begin
            wbuf_r[i] <= 8'h00;
         end
      end else if (st_r == ST_WRCYC) begin
         // line is deaf until the cycle ends
         if (twr_done) begin // [R11]
            st_r <= ST_IDLE;
            ptr_r <= 8'(waddr_r + {5'h00, wcnt_r}); // [R20]
            wcnt_r <= 3'h0;
         end
      end else if (!selected) begin
         st_r <= ST_IDLE; // [R18]
         oe_r <= 1'b0;
         wcnt_r <= 3'h0;
      end else if (start_det) begin
         // repeated start drops any collected write bytes
         st_r <= ST_RX;
         kind_r <= K_DEV;
         bit_cnt_r <= 4'h0;
         wcnt_r <= 3'h0; // [R9] [R15]
         oe_r <= 1'b0;
      end else if (stop_det) begin
         oe_r <= 1'b0; // [R6]
         if (kind_r == K_DATA && !rd_mode_r && wcnt_r != 3'h0) begin
            st_r <= ST_WRCYC; // [R8] [R10]
         end else begin
            st_r <= ST_IDLE;
            wcnt_r <= 3'h0;
         end
      end else begin
         case (st_r)
            ST_RX: begin
               if (scl_rise) begin
                  shift_r <= {shift_r[6:0], sda_s2_r}; // [R21]
                  bit_cnt_r <= bit_cnt_r + 4'h1;
               end else if (scl_fall && bit_cnt_r == BYTE_BITS) begin
                  bit_cnt_r <= 4'h0;
                  case (kind_r)
                     K_DEV: begin
                        if (shift_r[7:1] == DEV_ADDR7) begin
                           st_r <= ST_ACK; // [R1] [R4] [R7]
                           oe_r <= 1'b1;
                           rd_mode_r <= (shift_r[0] == RW_READ);
                        end else begin
                           st_r <= ST_IDLE;
                        end
                     end
                     K_MEM: begin
                        st_r <= ST_ACK; // [R4] [R7]
                        oe_r <= 1'b1;
                        ptr_r <= shift_r;
                        waddr_r <= shift_r;
                     end
                     default: begin
                        // a fifth byte gets no ack and is dropped
                        if (wcnt_r < MAX_WR_BYTES) begin // [R13]
                           wbuf_r[wcnt_r[1:0]] <= shift_r;
                           wcnt_r <= wcnt_r + 3'h1;
                           st_r <= ST_ACK; // [R7] [R14]
                           oe_r <= 1'b1;
                        end else begin
                           st_r <= ST_IDLE;
                        end
                     end
                  endcase
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  if (rd_mode_r) begin
                     st_r <= ST_TX; // [R1] [R4]
                     shift_r <= rd_byte;
                     oe_r <= !rd_byte[7]; // [R21]
                     bit_cnt_r <= 4'h0;
                  end else begin
                     st_r <= ST_RX;
                     oe_r <= 1'b0;
                     kind_r <= (kind_r == K_DEV) ? K_MEM : K_DATA;
                  end
               end
            end
            ST_TX: begin
               if (scl_fall) begin
                  if (bit_cnt_r == BYTE_BITS - 4'h1) begin
                     st_r <= ST_RACK;
                     oe_r <= 1'b0;
                     ptr_r <= ptr_r + 8'h01; // [R20]
                  end else begin
                     shift_r <= {shift_r[6:0], 1'b0};
                     oe_r <= !shift_r[6];
                     bit_cnt_r <= bit_cnt_r + 4'h1;
                  end
               end
            end
            ST_RACK: begin
               if (scl_rise) begin
                  ack_r <= !sda_s2_r;
               end else if (scl_fall) begin
                  if (ack_r) begin
                     st_r <= ST_TX; // [R5]
                     shift_r <= rd_byte;
                     oe_r <= !rd_byte[7];
                     bit_cnt_r <= 4'h0;
                  end else begin
                     st_r <= ST_IDLE; // [R6]
                  end
               end
            end
            default: begin
            end
         endcase
      end
   end

   // ****************************************
   // timed write cycle into memory
   // ****************************************
   always_ff @(posedge clk_sys) begin
      if (rst || st_r != ST_WRCYC) begin
         twr_cnt_r <= 24'h000000;
         wi_r <= 3'h0;
      end else begin
         twr_cnt_r <= twr_cnt_r + 24'h000001;
         if (wi_r < wcnt_r) begin
            wi_r <= wi_r + 3'h1;
         end
      end
   end

   logic [9:0] wr_map;
   assign wr_map = map_addr(8'(waddr_r + {5'h00, wi_r}), page_sel);

   // one byte per clock; writes to absent pages vanish
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         for (int i = 0; i < MEM_BYTES; i++) begin
            mem_r[i] <= MEM_RESET;
         end
      end else if (st_r == ST_WRCYC && wi_r < wcnt_r && wr_map[9]) begin
         mem_r[wr_map[8:0]] <= wbuf_r[wi_r[1:0]]; // [R10]
      end
   end

   assign busy = (st_r == ST_WRCYC);
   assign link.dev_sda_o = 1'b0;
   assign link.dev_sda_oe = oe_r;

endmodule : tw_dev

// file: core/tw_pkg.sv
// shared constants and types of the two-wire management link
package tw_pkg;
   // ****************************************
   // bus addressing
   // ****************************************
   localparam logic [6:0] DEV_ADDR7 = 7'h50;
   localparam logic RW_WRITE = 1'b0;
   localparam logic RW_READ = 1'b1;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [2:0] MAX_WR_BYTES = 3'h4;
   // ****************************************
   // memory map
   // ****************************************
   localparam logic [7:0] LOWER_TOP = 8'h7F;
   localparam logic [7:0] PAGE_SEL_ADDR = 8'h7F;
   localparam logic [7:0] PAGE_00 = 8'h00;
   localparam logic [7:0] PAGE_02 = 8'h02;
   localparam logic [7:0] PAGE_03 = 8'h03;
   localparam logic [1:0] BANK_LOWER = 2'h0;
   localparam logic [1:0] BANK_P00 = 2'h1;
   localparam logic [1:0] BANK_P02 = 2'h2;
   localparam logic [1:0] BANK_P03 = 2'h3;
   localparam int MEM_BYTES = 512;
   localparam logic [7:0] MEM_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_DATA = 8'h00;
   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 100;
   localparam int TWR_US = 10;
   localparam int TWR_CYC = (TWR_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SCL_QTR_CYC = 4;
   // ****************************************
   // state machines
   // ****************************************
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_RX = 6'h02,
      ST_ACK = 6'h04,
      ST_TX = 6'h08,
      ST_RACK = 6'h10,
      ST_WRCYC = 6'h20
   } tw_dev_st_t;
   typedef enum logic [2:0] {
      K_DEV = 3'h1,
      K_MEM = 3'h2,
      K_DATA = 3'h4
   } tw_kind_t;
   typedef enum logic [3:0] {
      H_IDLE = 4'h1,
      H_START = 4'h2,
      H_BYTE = 4'h4,
      H_STOP = 4'h8
   } tw_host_st_t;
   typedef enum logic [4:0] {
      HK_DEVW = 5'h01,
      HK_ADDR = 5'h02,
      HK_DATA = 5'h04,
      HK_DEVR = 5'h08,
      HK_RDATA = 5'h10
   } tw_hkind_t;
endpackage : tw_pkg

// file: core/tw_link_if.sv
// two-wire link between host controller and module
interface tw_link_if;
   logic scl;
   logic module_select_n;
   logic host_sda_o;
   logic host_sda_oe;
   logic dev_sda_o;
   logic dev_sda_oe;
   logic sda;
   // open drain: any enabled low driver pulls the line down
   assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));
   modport host (output scl, output module_select_n, output host_sda_o,
      output host_sda_oe, input sda);
   modport dev (input scl, input module_select_n, output dev_sda_o,
      output dev_sda_oe, input sda);
endinterface : tw_link_if

// file: core/tw_host.sv
// host end: two-wire master issuing reads and writes to the module
module tw_host import tw_pkg::*; #(
   parameter int QTR_CYCLES = SCL_QTR_CYC
) (
   input wire logic clk_sys,
   input wire logic rst,
   tw_link_if.host link,
   input wire logic select_n,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic cmd_write,
   input wire logic cmd_random,
   input wire logic [7:0] cmd_addr,
   input wire logic [2:0] cmd_len,
   input wire logic [31:0] cmd_wdata,
   output logic rd_valid,
   output logic [7:0] rd_data,
   output logic done,
   output logic nack_err
);

   // ****************************************
   // sync and quarter-bit timebase
   // ****************************************
   logic sda_s1_r;
   logic sda_s2_r;
   logic msel_r;
   tw_host_st_t st_r;
   logic [7:0] qdiv_r;
   logic [1:0] q_r;
   logic qtick;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sda_s1_r <= 1'b1;
         sda_s2_r <= 1'b1;
         msel_r <= 1'b1;
      end else begin
         sda_s1_r <= link.sda;
         sda_s2_r <= sda_s1_r;
         msel_r <= select_n;
      end
   end

   assign qtick = (st_r != H_IDLE) && (qdiv_r == 8'(QTR_CYCLES - 1));

   // scl is divided down here, so it only runs during a transfer
   always_ff @(posedge clk_sys) begin
      if (rst || st_r == H_IDLE) begin
         qdiv_r <= 8'h00;
         q_r <= 2'h0;
      end else if (qtick) begin
         qdiv_r <= 8'h00;
         q_r <= q_r + 2'h1;
      end else begin
         qdiv_r <= qdiv_r + 8'h01;
      end
   end

   // ****************************************
   // transfer sequencer
   // ****************************************
   tw_hkind_t kind_r;
   logic scl_r;
   logic oe_r;
   logic [7:0] sh_r;
   logic [3:0] bit_cnt_r;
   logic wr_r;
   logic rd_phase_r;
   logic [7:0] addr_r;
   logic [2:0] len_r;
   logic [2:0] idx_r;
   logic [31:0] wdata_r;
   logic ackok_r;

   function automatic logic [7:0] byte_of(input logic [31:0] w, input logic [2:0] i);
      byte_of = w[8 * i[1:0] +: 8];
   endfunction : byte_of

   always_ff @(posedge clk_sys) begin
      rd_valid <= 1'b0;
      done <= 1'b0;
      if (rst) begin
         st_r <= H_IDLE;
         kind_r <= HK_DEVW;
         scl_r <= 1'b1;
         oe_r <= 1'b0;
         sh_r <= 8'h00;
         bit_cnt_r <= 4'h0;
         wr_r <= 1'b0;
         rd_phase_r <= 1'b0;
         addr_r <= 8'h00;
         len_r <= 3'h0;
         idx_r <= 3'h0;
         wdata_r <= 32'h00000000;
         ackok_r <= 1'b0;
         rd_data <= 8'h00;
         nack_err <= 1'b0;
      end else begin
         case (st_r)
            H_IDLE: begin
               if (cmd_valid) begin
                  st_r <= H_START;
                  wr_r <= cmd_write;
                  rd_phase_r <= !cmd_write && !cmd_random;
                  addr_r <= cmd_addr;
                  // write bursts never exceed four bytes
                  len_r <= (cmd_write && cmd_len > MAX_WR_BYTES) ? MAX_WR_BYTES : cmd_len; // [R13]
                  wdata_r <= cmd_wdata;
                  nack_err <= 1'b0;
               end
            end
            H_START: begin
               if (qtick) begin
                  case (q_r)
                     2'h0: oe_r <= 1'b0;
                     2'h1: scl_r <= 1'b1;
                     2'h2: oe_r <= 1'b1;
                     default: begin
                        scl_r <= 1'b0;
                        st_r <= H_BYTE;
                        bit_cnt_r <= 4'h0;
                        idx_r <= 3'h0;
                        sh_r <= {DEV_ADDR7, rd_phase_r ? RW_READ : RW_WRITE}; // [R1] [R3]
                        kind_r <= rd_phase_r ? HK_DEVR : HK_DEVW;
                     end
                  endcase
               end
            end
            H_BYTE: begin
               if (qtick) begin
                  case (q_r)
                     2'h0: begin
                        if (kind_r == HK_RDATA) begin
                           // last byte left undriven: the nack
                           oe_r <= (bit_cnt_r == BYTE_BITS) && (len_r > 3'h1); // [R2] [R5] [R6]
                        end else begin
                           oe_r <= (bit_cnt_r != BYTE_BITS) && !sh_r[7]; // [R21]
                        end
                     end
                     2'h1: scl_r <= 1'b1;
                     2'h2: begin
                        if (kind_r == HK_RDATA && bit_cnt_r != BYTE_BITS) begin
                           sh_r <= {sh_r[6:0], sda_s2_r};
                        end
                        if (kind_r != HK_RDATA && bit_cnt_r == BYTE_BITS) begin
                           ackok_r <= !sda_s2_r;
                        end
                     end
                     default: begin
                        scl_r <= 1'b0;
                        if (bit_cnt_r != BYTE_BITS) begin
                           bit_cnt_r <= bit_cnt_r + 4'h1;
                           if (kind_r != HK_RDATA) begin
                              sh_r <= {sh_r[6:0], 1'b0};
                           end
                        end else begin
                           bit_cnt_r <= 4'h0;
                           if (kind_r == HK_RDATA) begin
                              rd_valid <= 1'b1;
                              rd_data <= sh_r;
                              len_r <= len_r - 3'h1;
                              if (len_r <= 3'h1) begin
                                 st_r <= H_STOP; // [R6]
                              end
                           end else if (!ackok_r) begin
                              nack_err <= 1'b1;
                              st_r <= H_STOP;
                           end else begin
                              case (kind_r)
                                 HK_DEVW: begin
                                    kind_r <= HK_ADDR;
                                    sh_r <= addr_r; // [R3] [R7]
                                 end
                                 HK_ADDR: begin
                                    if (wr_r) begin
                                       kind_r <= HK_DATA;
                                       sh_r <= byte_of(wdata_r, 3'h0);
                                       idx_r <= 3'h1;
                                    end else begin
                                       // only reads use the restart form
                                       rd_phase_r <= 1'b1; // [R3] [R12]
                                       st_r <= H_START;
                                    end
                                 end
                                 HK_DATA: begin
                                    if (idx_r < len_r) begin
                                       sh_r <= byte_of(wdata_r, idx_r); // [R13]
                                       idx_r <= idx_r + 3'h1;
                                    end else begin
                                       st_r <= H_STOP; // [R8] [R15]
                                    end
                                 end
                                 default: kind_r <= HK_RDATA;
                              endcase
                           end
                        end
                     end
                  endcase
               end
            end
            default: begin
               if (qtick) begin
                  case (q_r)
                     2'h0: oe_r <= 1'b1;
                     2'h1: scl_r <= 1'b1;
                     2'h2: oe_r <= 1'b0;
                     default: begin
                        st_r <= H_IDLE;
                        done <= 1'b1;
                     end
                  endcase
               end
            end
         endcase
      end
   end

   assign cmd_ready = (st_r == H_IDLE);
   assign link.scl = scl_r;
   assign link.host_sda_o = 1'b0;
   assign link.host_sda_oe = oe_r;
   assign link.module_select_n = msel_r;

endmodule : tw_host

// file: dv/tw_link_chk.sv
// concurrent checks on the two-wire link between host and module
module tw_link_chk #(
   parameter int TWR_CYCLES = 20
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic scl,
   input wire logic module_select_n,
   input wire logic host_sda_oe,
   input wire logic dev_sda_oe,
   input wire logic sda,
   input wire logic busy
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   // ****************************************
   // write cycle length
   // ****************************************
   logic [15:0] busy_cnt_r;
   always_ff @(posedge clk_sys) begin
      if (rst) busy_cnt_r <= 16'h0000;
      else if (busy) busy_cnt_r <= busy_cnt_r + 16'h0001;
      else busy_cnt_r <= 16'h0000;
   end
   // ****************************************
   // assertions
   // ****************************************
   a_busy_len_exact: assert property ($fell(busy) |-> busy_cnt_r == TWR_CYCLES)
      else $error("write cycle length wrong");
   a_busy_stays_deaf: assert property (busy |-> !dev_sda_oe)
      else $error("module drives sda while busy");
   a_busy_after_stop: assert property ($rose(busy) |-> scl && sda)
      else $error("write cycle began without stop");
   a_deselect_quiet: assert property (module_select_n [*5] |-> !dev_sda_oe)
      else $error("module drives sda while deselected");
   a_oe_scl_low: assert property ($changed(dev_sda_oe) |-> !scl)
      else $error("module sda changed with scl high");
   a_sda_stable_high: assert property (scl && $past(scl) && $changed(sda) |-> !$past(dev_sda_oe))
      else $error("module moved sda during scl high");
   a_ack_held_bit: assert property ($rose(dev_sda_oe) |-> dev_sda_oe [*4])
      else $error("module low pulse too short");
   a_stop_released: assert property (scl && $past(scl) && $rose(sda) |-> !dev_sda_oe)
      else $error("module still driving at stop");
   c_write_cycle: cover property ($rose(busy));
   c_module_drives: cover property ($rose(dev_sda_oe));
   c_deselect: cover property ($rose(module_select_n));
endmodule : tw_link_chk

// file: dv/tw_mem_access_test.sv
// bench joining host and module ends over the two-wire link
module tw_mem_access_test import tw_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int INTERNAL_WRITE_CYCLE_TIME = 20; // short write cycle keeps the run brief
   logic clk_sys, rst, select_n, cmd_valid, cmd_write, cmd_random;
   logic [7:0] cmd_addr;
   logic [2:0] cmd_len;
   logic [31:0] cmd_wdata;
   logic cmd_ready, rd_valid, done, nack_err, busy;
   logic [7:0] rd_data, page_sel;
   logic [7:0] got[$];
   int n_fail = 0;
   int cmp_count = 0;
   int p;
   // ****************************************
   // structure
   // ****************************************
   tw_link_if tw_link_if_i();
   tw_dev #(.TWR_CYCLES(INTERNAL_WRITE_CYCLE_TIME)) tw_dev_i(.clk_sys(clk_sys), .rst(rst), .link(tw_link_if_i),
      .busy(busy), .page_sel(page_sel));
   tw_host tw_host_i(.clk_sys(clk_sys), .rst(rst), .link(tw_link_if_i), .select_n(select_n),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write),
      .cmd_random(cmd_random), .cmd_addr(cmd_addr), .cmd_len(cmd_len), .cmd_wdata(cmd_wdata),
      .rd_valid(rd_valid), .rd_data(rd_data), .done(done), .nack_err(nack_err));
   tw_link_chk #(.TWR_CYCLES(INTERNAL_WRITE_CYCLE_TIME)) tw_link_chk_i(.clk_sys(clk_sys), .rst(rst),
      .scl(tw_link_if_i.scl), .module_select_n(tw_link_if_i.module_select_n),
      .host_sda_oe(tw_link_if_i.host_sda_oe), .dev_sda_oe(tw_link_if_i.dev_sda_oe),
      .sda(tw_link_if_i.sda), .busy(busy));
   // ****************************************
   // tasks
   // ****************************************
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask : check
   task automatic report_and_stop();
      $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : report_and_stop
   // one host command; fast skips the wait for the write cycle
   task automatic run(input logic w, input logic r, input logic [7:0] a, input logic [2:0] n,
         input logic [31:0] wd, input logic fast, input logic en);
      int k;
      got.delete();
      cmd_valid <= 1'b1;
      cmd_write <= w;
      cmd_random <= r;
      cmd_addr <= a;
      cmd_len <= n;
      cmd_wdata <= wd;
      // outputs are looked at mid-cycle, where they have settled
      @(negedge clk_sys);
      for (k = 0; k < 99 && cmd_ready !== 1'b1; k++) @(negedge clk_sys);
      @(posedge clk_sys);
      cmd_valid <= 1'b0;
      for (k = 0; k < 3000 && done !== 1'b1; k++) begin
         @(negedge clk_sys);
         if (rd_valid === 1'b1) got.push_back(rd_data);
      end
      if (k >= 3000) n_fail++;
      @(posedge clk_sys);
      check({7'h00, nack_err}, {7'h00, en});
      if (w && !fast) repeat (INTERNAL_WRITE_CYCLE_TIME + 8) @(posedge clk_sys);
   endtask : run
   // ****************************************
   // clock, watchdog, tests
   // ****************************************
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   initial begin
      repeat (60000) @(posedge clk_sys);
      n_fail++;
      report_and_stop();
   end
   initial begin
      rst = 1'b1;
      select_n = 1'b0;
      cmd_valid = 1'b0;
      cmd_write = 1'b0;
      cmd_random = 1'b0;
      cmd_addr = 8'h00;
      cmd_len = 3'h1;
      cmd_wdata = 32'h0;
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      run(1'b1, 1'b1, 8'h10, 3'h1, 32'h5A, 1'b0, 1'b0);
      run(1'b0, 1'b1, 8'h10, 3'h1, 32'h0, 1'b0, 1'b0);
      check(got[0], 8'h5A);
      run(1'b1, 1'b1, 8'h20, 3'h4, 32'h44332211, 1'b0, 1'b0);
      run(1'b0, 1'b1, 8'h20, 3'h3, 32'h0, 1'b0, 1'b0);
      check(8'(got.size()), 8'h03);
      for (p = 0; p < 3; p++) check(got[p], 8'(8'h11 * (p + 1)));
      run(1'b0, 1'b0, 8'h00, 3'h1, 32'h0, 1'b0, 1'b0);
      check(got[0], 8'h44);
      run(1'b1, 1'b1, 8'h30, 3'h2, 32'hBBAA, 1'b1, 1'b0);
      run(1'b0, 1'b1, 8'h30, 3'h1, 32'h0, 1'b0, 1'b1);
      repeat (INTERNAL_WRITE_CYCLE_TIME) @(posedge clk_sys);
      run(1'b0, 1'b1, 8'h30, 3'h2, 32'h0, 1'b0, 1'b0);
      check(got[1], 8'hBB);
      select_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      run(1'b0, 1'b1, 8'h10, 3'h1, 32'h0, 1'b0, 1'b1);
      select_n <= 1'b0;
      repeat (4) @(posedge clk_sys);
      // every page, 01 included, is sent a distinct byte at address 80; page 01 drops it and reads back 00
      for (p = 0; p < 4; p++) begin
         run(1'b1, 1'b1, PAGE_SEL_ADDR, 3'h1, 32'(p), 1'b0, 1'b0);
         check(page_sel, 8'(p));
         run(1'b1, 1'b1, 8'h80, 3'h1, 32'hC0 + 32'(p), 1'b0, 1'b0);
      end
      for (p = 3; p >= 0; p--) begin
         run(1'b1, 1'b1, PAGE_SEL_ADDR, 3'h1, 32'(p), 1'b0, 1'b0);
         run(1'b0, 1'b1, 8'h80, 3'h1, 32'h0, 1'b0, 1'b0);
         check(got[0], (p == 1) ? 8'h00 : 8'(8'hC0 + p));
      end
      run(1'b0, 1'b1, 8'h10, 3'h1, 32'h0, 1'b0, 1'b0);
      check(got[0], 8'h5A);
      report_and_stop();
   end
endmodule : tw_mem_access_test
